// ==== shared/pbcd_pkg.sv ====
// Constants, types and helpers for the presettable BCD decade counter.
// Assumes one clock domain and a classic Wishbone register slave.
// Contract
// - Count modulo ten in 8421 BCD weights.
// - Enabled count from nine goes to zero.
// - Outputs change on rising clock edge, except async clear and trickle-gated terminal count.
// - Priority: clear, then load, then count, then hold.
// - Async variant: low clear forces zero immediately.
// - Sync variant: low clear zeroes at next edge.
// - Low load copies preset data at next edge.
// - Count only when both enables are high.
// - Either enable low holds the count.
// - Terminal count is nine decode and trickle enable.
// - Illegal states rejoin sequence within two counts.
package pbcd_pkg;

    // Counter geometry
    localparam int unsigned CNT_W = 4;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_NINE = 4'h9;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // Register bus geometry
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;

    // Register byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SWPRESET = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;

    // Field positions
    localparam int unsigned STS_TC_BIT = 4;
    localparam int unsigned STS_ILLEGAL_BIT = 5;
    localparam int unsigned CMD_LOAD_BIT = 0;

    // Reset values
    localparam logic [31:0] DAT_ZERO = 32'h0000_0000;
    localparam logic [3:0] SWPRESET_RST = 4'h0;

    // Wishbone request bundle from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } pbcd_wb_req_t;

    // Whole state of the counter block
    typedef struct packed {
        logic [3:0] count;
        logic [3:0] swpreset;
        logic sw_load;
        logic ack;
        logic [31:0] rdat;
    } pbcd_state_t;

    localparam pbcd_state_t STATE_RST = '{
        count: CNT_ZERO,
        swpreset: SWPRESET_RST,
        sw_load: 1'b0,
        ack: 1'b0,
        rdat: DAT_ZERO
    };

    // Next value when counting; illegal states fold back fast
    function automatic logic [3:0] pbcd_next(input logic [3:0] cur);
        logic [3:0] res;
        res = CNT_ZERO;
        unique case (cur)
            CNT_NINE: res = CNT_ZERO;
            4'hA: res = 4'hB;
            4'hB: res = 4'h6;
            4'hC: res = 4'hD;
            4'hD: res = 4'h4;
            4'hE: res = 4'hF;
            4'hF: res = 4'h2;
            default: res = cur + CNT_ONE;
        endcase
        return res;
    endfunction : pbcd_next

endpackage : pbcd_pkg

// ==== core/pbcd_counter.sv ====
// Presettable BCD decade counter with a small Wishbone register window.
// Assumes pins synchronous to i_clock and a classic single-cycle master.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module pbcd_counter #(
    parameter bit ASYNC_CLEAR = 1'b1
) (
    // Clock and system reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Clear inputs; only the one picked by ASYNC_CLEAR is used
    input wire logic i_async_clear_n,
    input wire logic i_sync_clear_n,
    // Load and count controls
    input wire logic i_load_n,
    input wire logic i_count_enable_parallel,
    input wire logic i_count_enable_trickle,
    input wire logic [3:0] i_preset_data,
    // Counter outputs
    output logic [3:0] o_count_out,
    output logic o_terminal_count,
    // Wishbone slave
    input wire pbcd_pkg::pbcd_wb_req_t i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);

    // Registered and next state
    pbcd_pkg::pbcd_state_t state_ff;
    pbcd_pkg::pbcd_state_t nxt_state;

    // Decoded controls
    logic clear_now;
    logic load_now;
    logic count_now;
    logic wb_req;
    logic wb_done;
    logic tc;
    logic illegal;

    // Sync clear exists only in the sync variant
    assign clear_now = !ASYNC_CLEAR && !i_sync_clear_n;
    // Pin load or a pending software load
    assign load_now = !i_load_n || state_ff.sw_load;
    // Both enables must be high
    assign count_now = i_count_enable_parallel && i_count_enable_trickle;
    // New request, not yet answered
    assign wb_req = i_wb.cyc && i_wb.stb && !state_ff.ack;
    // Edge at which the master sees ack: writes land here
    assign wb_done = i_wb.cyc && i_wb.stb && state_ff.ack;

    // Full decode of nine; it is combinational, so it may spike between
    // states and must only feed enables of later stages
    assign tc = state_ff.count[0] && !state_ff.count[1] && !state_ff.count[2]
        && state_ff.count[3] && i_count_enable_trickle;
    assign illegal = state_ff.count > pbcd_pkg::CNT_NINE;

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        // Mode priority: clear, load, count, hold
        if (clear_now) begin
            nxt_state.count = pbcd_pkg::CNT_ZERO;
        end else if (load_now) begin
            // Pin data wins over the software preset
            nxt_state.count = !i_load_n ? i_preset_data : state_ff.swpreset;
        end else if (count_now) begin
            // Weighted 8-4-2-1, nine wraps to zero, illegal folds back
            nxt_state.count = pbcd_pkg::pbcd_next(state_ff.count);
        end else begin
            // Hold across the edge
            nxt_state.count = state_ff.count;
        end
        // Software load is a one-edge request
        nxt_state.sw_load = 1'b0;
        // Ack one cycle after the request, dropped the cycle after
        nxt_state.ack = wb_req;
        // Read data is captured as ack rises
        if (wb_req) begin
            unique case (i_wb.adr)
                pbcd_pkg::REG_STATUS: begin
                    nxt_state.rdat = pbcd_pkg::DAT_ZERO;
                    nxt_state.rdat[3:0] = state_ff.count;
                    nxt_state.rdat[pbcd_pkg::STS_TC_BIT] = tc;
                    nxt_state.rdat[pbcd_pkg::STS_ILLEGAL_BIT] = illegal;
                end
                pbcd_pkg::REG_SWPRESET: begin
                    nxt_state.rdat = pbcd_pkg::DAT_ZERO;
                    nxt_state.rdat[3:0] = state_ff.swpreset;
                end
                // Command reads zero; unmapped reads zero
                default: begin
                    nxt_state.rdat = pbcd_pkg::DAT_ZERO;
                end
            endcase
        end
        // Writes take effect at the acknowledged edge, low lane only
        if (wb_done && i_wb.we && i_wb.sel[0]) begin
            if (i_wb.adr == pbcd_pkg::REG_SWPRESET) begin
                nxt_state.swpreset = i_wb.dat[3:0];
            end
            if (i_wb.adr == pbcd_pkg::REG_CMD) begin
                nxt_state.sw_load = i_wb.dat[pbcd_pkg::CMD_LOAD_BIT];
            end
        end
    end

    // State register; the variant decides whether the clear is asynchronous
    generate
        if (ASYNC_CLEAR) begin : g_async
            // Clear acts without the clock and overrides everything
            always_ff @(posedge i_clock or negedge i_async_clear_n) begin
                if (!i_async_clear_n) begin
                    state_ff <= pbcd_pkg::STATE_RST;
                end else if (!i_rstn) begin
                    state_ff <= pbcd_pkg::STATE_RST;
                end else begin
                    state_ff <= nxt_state;
                end
            end
        end else begin : g_sync
            // Every change on the rising edge only
            always_ff @(posedge i_clock) begin
                if (!i_rstn) begin
                    state_ff <= pbcd_pkg::STATE_RST;
                end else begin
                    state_ff <= nxt_state;
                end
            end
        end
    endgenerate

    // Outputs
    assign o_count_out = state_ff.count;
    assign o_terminal_count = tc;
    assign o_wb_dat = state_ff.rdat;
    assign o_wb_ack = state_ff.ack;

    // Checks

    a_nine_wraps: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (o_count_out == pbcd_pkg::CNT_NINE && count_now && !load_now && !clear_now)
        |=> (o_count_out == pbcd_pkg::CNT_ZERO))
        else $error("count did not wrap from nine to zero");

    a_legal_stays: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (o_count_out <= pbcd_pkg::CNT_NINE && !load_now)
        |=> (o_count_out <= pbcd_pkg::CNT_NINE))
        else $error("count left the decimal range");

    a_count_step: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (o_count_out < pbcd_pkg::CNT_NINE && count_now && !load_now && !clear_now)
        |=> (o_count_out == $past(o_count_out) + pbcd_pkg::CNT_ONE))
        else $error("count did not step by one");

    a_hold_value: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (!count_now && !load_now && !clear_now) |=> $stable(o_count_out))
        else $error("count moved while disabled");

    a_load_wins: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (!i_load_n && !clear_now) |=> (o_count_out == $past(i_preset_data)))
        else $error("preset data not loaded");

    a_tc_decode: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        o_terminal_count == (o_count_out == pbcd_pkg::CNT_NINE && i_count_enable_trickle))
        else $error("terminal count decode wrong");

    a_recover_two: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (illegal && count_now && !load_now && !clear_now) ##1
        (count_now && !load_now && !clear_now)
        |=> (o_count_out <= pbcd_pkg::CNT_NINE))
        else $error("illegal state not recovered in two counts");

    a_sync_clear: assert property (
        @(posedge i_clock) disable iff (!i_rstn || ASYNC_CLEAR)
        !i_sync_clear_n |=> (o_count_out == pbcd_pkg::CNT_ZERO))
        else $error("sync clear did not zero the count");

    a_async_clear: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !ASYNC_CLEAR)
        !i_async_clear_n |-> (o_count_out == pbcd_pkg::CNT_ZERO))
        else $error("async clear did not zero the count");

    a_ack_pulse: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");

    // Terminal count, priority and bus checks

    // Terminal count may only show in state nine; any other state
    // raising it would let a later stage count at the wrong time,
    // so the decode is watched on every edge
    a_tc_only_nine: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (o_count_out != pbcd_pkg::CNT_NINE) |-> !o_terminal_count)
        else $error("terminal count high outside state nine");

    // Trickle enable gates terminal count directly, so a low trickle
    // enable must stop the ripple into the next stage in the same
    // cycle, not one edge later
    a_tc_trickle: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        !i_count_enable_trickle |-> !o_terminal_count)
        else $error("terminal count high with trickle enable low");

    // Load beats counting: both enables high together with a low
    // load still takes the preset data and does not step the count
    // from the old value
    a_load_over_count: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (!i_load_n && !clear_now && count_now)
        |=> (o_count_out == $past(i_preset_data)))
        else $error("count won over a pin load");

    // In the synchronous build the clear beats a load at the same
    // edge; only meaningful there, so the other build switches it
    // off through the disable condition
    a_clear_over_load: assert property (
        @(posedge i_clock) disable iff (!i_rstn || ASYNC_CLEAR)
        (!i_sync_clear_n && !i_load_n) |=> (o_count_out == pbcd_pkg::CNT_ZERO))
        else $error("load won over the synchronous clear");

    // The asynchronous build ignores the synchronous clear pin; a
    // low level there with nothing else active must leave the count
    // where it was
    a_sync_ignored: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n || !ASYNC_CLEAR)
        (!i_sync_clear_n && !load_now && !count_now) |=> $stable(o_count_out))
        else $error("unused synchronous clear moved the count");

    // A software load request takes the stored preset on the edge
    // after the command write, unless the load pin is also low, in
    // which case the pin data wins
    a_sw_load: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (state_ff.sw_load && i_load_n && !clear_now)
        |=> (o_count_out == $past(state_ff.swpreset)))
        else $error("software load did not apply the preset");

    // The software load flag must fall after one edge; a stuck flag
    // would keep reloading and freeze the counter
    a_sw_load_pulse: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        state_ff.sw_load |=> !state_ff.sw_load)
        else $error("software load request held too long");

    // Odd non-decimal codes are the second step of the fold-back, so
    // one more count must land back in the decimal range whatever the
    // first illegal code was
    a_odd_illegal: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (illegal && state_ff.count[0] && count_now && !load_now && !clear_now)
        |=> (o_count_out <= pbcd_pkg::CNT_NINE))
        else $error("odd illegal code did not rejoin the sequence");

    // Either enable alone low holds the count; checked one enable at
    // a time so that a decode using only one of them would be caught
    // here rather than passing the combined hold check
    a_hold_trickle: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (!i_count_enable_trickle && !load_now && !clear_now) |=> $stable(o_count_out))
        else $error("count moved with trickle enable low");

    // Same hold check for the parallel enable on its own; a cascade
    // relies on it to freeze every stage while the first is stopped
    // by its own trickle input
    a_hold_parallel: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (!i_count_enable_parallel && !load_now && !clear_now) |=> $stable(o_count_out))
        else $error("count moved with parallel enable low");

    // System reset leaves the count at zero and the bus idle; only
    // the asynchronous clear may cut in while reset is held, and it
    // gives the same values anyway
    a_reset_zero: assert property (
        @(posedge i_clock) disable iff (!i_async_clear_n)
        !i_rstn |=> (o_count_out == pbcd_pkg::CNT_ZERO && !o_wb_ack))
        else $error("reset did not clear count and ack");

    // In the asynchronous build the clear also drops the bus answer,
    // so an interrupted transfer is never acknowledged while the
    // block is held clear
    a_async_bus: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !ASYNC_CLEAR)
        !i_async_clear_n |-> (!o_wb_ack && o_wb_dat == pbcd_pkg::DAT_ZERO))
        else $error("async clear left the bus answer standing");

    // Every new request is answered on the very next edge; a master
    // that waits for ack would otherwise stall until its own timeout
    // and the slave would look dead
    a_ack_follows: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        wb_req |=> o_wb_ack)
        else $error("request not acknowledged on the next edge");

    // Ack only ever answers a request taken on the previous edge, so
    // a stray pulse cannot complete a transfer that the master has
    // not yet started
    a_ack_needs_req: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        !wb_req |=> !o_wb_ack)
        else $error("ack without a request");

    // Read data stands until the next request is taken, so a master
    // that samples late in the ack cycle still sees the value that
    // was captured for it
    a_rdat_stands: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        !wb_req |=> $stable(o_wb_dat))
        else $error("read data changed without a request");

    // A status read returns the count as it stood when the request
    // was taken, in the low four bits with weight one at bit zero,
    // which is the value the master will see with ack
    a_status_count: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (wb_req && i_wb.adr == pbcd_pkg::REG_STATUS)
        |=> (o_wb_dat[3:0] == $past(o_count_out)))
        else $error("status read did not return the count");

    // A preset write lands at the acknowledged edge and nowhere
    // else; the stored value must be the written low nibble once the
    // edge has passed
    a_preset_write: assert property (
        @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
        (wb_done && i_wb.we && i_wb.sel[0] && i_wb.adr == pbcd_pkg::REG_SWPRESET)
        |=> (state_ff.swpreset == $past(i_wb.dat[3:0])))
        else $error("preset write did not land");

endmodule : pbcd_counter

// ==== verif/pbcd_sys_model.sv ====
// System-side driver of the counter's clear, load, enable and preset pins.
// Assumes the bench calls drive() and that pins move only at rising edges.
`timescale 1ns/1ns
module pbcd_sys_model (
    // Clock
    input wire logic i_clock,
    // Control pins toward the counter
    output logic o_async_clear_n,
    output logic o_sync_clear_n,
    output logic o_load_n,
    output logic o_count_enable_parallel,
    output logic o_count_enable_trickle,
    output logic [3:0] o_preset_data
);
    // Idle levels: clears and load inactive, counting off
    initial begin
        {o_async_clear_n, o_sync_clear_n, o_load_n} = 3'h7;
        {o_count_enable_parallel, o_count_enable_trickle} = 2'h0;
        o_preset_data = 4'h0;
    end

    // All pins move together at one edge; terminal count is never fed back
    // as a clock or reset, since it may spike while decoding
    task automatic drive(input logic [4:0] ctl, input logic [3:0] dat);
        @(posedge i_clock);
        {o_async_clear_n, o_sync_clear_n, o_load_n} <= ctl[4:2];
        {o_count_enable_parallel, o_count_enable_trickle} <= ctl[1:0];
        o_preset_data <= dat;
    endtask : drive
endmodule : pbcd_sys_model

// ==== verif/test_presettable_bcd_decade_counter.sv ====
// Self-checking bench: pin driver, reference count and register bus.
// Assumes both clear builds share the pins and a one-cycle bus ack.
`timescale 1ns/1ns
module test_presettable_bcd_decade_counter;
    logic i_clock;
    logic i_rstn;
    logic aclr_n, sclr_n, ld_n, cep, count_enable_trickle, ack, tc, sw_pend;
    logic [3:0] pdat, count, exp, swp, count_s;
    logic [31:0] rdat, rd;
    logic [3:0] ill [4] = '{4'hA, 4'hC, 4'hE, 4'hF};
    pbcd_pkg::pbcd_wb_req_t wb;
    int miscompares;
    int n_tests;

    pbcd_sys_model sys (.i_clock(i_clock), .o_async_clear_n(aclr_n), .o_sync_clear_n(sclr_n),
        .o_load_n(ld_n), .o_count_enable_parallel(cep), .o_count_enable_trickle(count_enable_trickle),
        .o_preset_data(pdat));
    pbcd_counter dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_async_clear_n(aclr_n),
        .i_sync_clear_n(sclr_n), .i_load_n(ld_n), .i_count_enable_parallel(cep),
        .i_count_enable_trickle(count_enable_trickle), .i_preset_data(pdat), .o_count_out(count),
        .o_terminal_count(tc), .i_wb(wb), .o_wb_dat(rdat), .o_wb_ack(ack));
    // Synchronous-clear build on the same pins; its unused clear is idle
    pbcd_counter #(.ASYNC_CLEAR(1'b0)) dut_sync (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_async_clear_n(1'b1), .i_sync_clear_n(sclr_n), .i_load_n(ld_n),
        .i_count_enable_parallel(cep), .i_count_enable_trickle(count_enable_trickle), .i_preset_data(pdat),
        .o_count_out(count_s), .o_terminal_count(), .i_wb(wb), .o_wb_dat(), .o_wb_ack());

    // 50 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    // Reference count; codes above nine follow the chosen fast fold-back
    always @(posedge i_clock or negedge aclr_n) begin
        if (!aclr_n || !i_rstn) begin
            exp <= 4'h0;
            swp <= 4'h0;
        end else if (!ld_n) begin
            exp <= pdat;
        end else if (sw_pend) begin
            exp <= swp;
        end else if (cep && count_enable_trickle) begin
            case (exp)
                4'h9: exp <= 4'h0;
                4'hB: exp <= 4'h6;
                4'hD: exp <= 4'h4;
                4'hF: exp <= 4'h2;
                default: exp <= exp + 4'h1;
            endcase
        end
    end

    // Outputs compared every cycle, mid-period where they have settled
    always @(negedge i_clock) begin
        if (i_rstn) begin
            check({28'h0, count}, {28'h0, exp});
            check({31'h0, tc}, {31'h0, exp == 4'h9 && count_enable_trickle});
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check

    // One classic cycle, held until ack is sampled high at a rising edge
    task automatic wb_cyc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge i_clock);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        do @(posedge i_clock); while (ack !== 1'b1);
        rd = rdat;
        wb <= '0;
        if (we && adr == pbcd_pkg::REG_SWPRESET) swp <= dat[3:0];
        // Software load lands one edge after the write edge
        if (we && adr == pbcd_pkg::REG_CMD && dat[0]) begin
            sw_pend <= 1'b1;
            @(posedge i_clock);
            sw_pend <= 1'b0;
        end
    endtask : wb_cyc

    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog at 5000 cycles, far beyond the fewer than a hundred cycles the tests take
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        miscompares = 0;
        n_tests = 0;
        i_rstn = 1'b0;
        wb = '0;
        sw_pend = 1'b0;
        rd = 32'h0;
        repeat (3) @(posedge i_clock);
        i_rstn <= 1'b1;
        // Free count through a wrap, then load over count and hold at nine
        sys.drive(5'h1F, 4'h0);
        repeat (12) @(posedge i_clock);
        sys.drive(5'h1B, 4'h9);
        sys.drive(5'h1E, 4'h9);
        sys.drive(5'h1D, 4'h9);
        sys.drive(5'h1F, 4'h9);
        repeat (2) @(posedge i_clock);
        // Non-decimal presets must be back in range after two counts
        foreach (ill[i]) begin
            sys.drive(5'h1B, ill[i]);
            sys.drive(5'h1F, ill[i]);
            repeat (2) @(posedge i_clock);
            @(negedge i_clock);
            check({31'h0, count <= 4'h9}, 32'h1);
        end
        // Sync clear is inert in this build; async clear beats a load at once
        sys.drive(5'h17, 4'h0);
        sys.drive(5'h0B, 4'h7);
        @(negedge i_clock);
        check({28'h0, count_s}, 32'h0);
        sys.drive(5'h1C, 4'h0);
        @(negedge i_clock);
        check({28'h0, count_s}, 32'h7);
        // Register window: preset, readback, status, software load, hole
        wb_cyc(1'b1, pbcd_pkg::REG_SWPRESET, 32'h0000_0007);
        wb_cyc(1'b0, pbcd_pkg::REG_SWPRESET, 32'h0);
        check(rd, 32'h0000_0007);
        wb_cyc(1'b0, pbcd_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h0);
        wb_cyc(1'b1, pbcd_pkg::REG_CMD, 32'h0000_0001);
        wb_cyc(1'b0, pbcd_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h0000_0007);
        wb_cyc(1'b1, 8'h0C, 32'h0000_000F);
        wb_cyc(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0);
        repeat (2) @(posedge i_clock);
        finish_test();
    end
endmodule : test_presettable_bcd_decade_counter
